/* File: src/swk_pkg.sv */
// shared constants for the standby wake counter
package swk_pkg;

    localparam int          CNT_W           = 40;
    localparam int          BYTE_W          = 8;
    localparam int          NUM_BYTES       = 5;
    localparam int          ADDR_W          = 8;
    localparam int          IDX_W           = 3;

    // byte-wide configuration map
    localparam logic [7:0]  ADR_COUNTER     = 8'h40;
    localparam logic [7:0]  ADR_MATCH       = 8'h48;
    localparam logic [7:0]  ADR_MATCHBIT    = 8'h50;
    localparam logic [7:0]  ADR_CTRL        = 8'h58;

    // control/status byte layout
    localparam int          CTL_RTC_RST     = 7;
    localparam int          CTL_CNT_EN      = 6;
    localparam int          CTL_WAKE_MATCH  = 5;
    localparam int          CTL_MODE_HI     = 4;
    localparam int          CTL_MODE_LO     = 3;
    localparam int          CTL_CLR_MATCH   = 2;
    localparam int          CTL_CLR_N       = 1;
    localparam int          CTL_OSC_EN      = 0;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    localparam logic [CNT_W-1:0] CNT_ZERO   = 40'h00_0000_0000;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;

    // prescaler
    localparam int          PRESCALE_DIV    = 128;
    localparam int          FIRST_TICK_EDGES = 64;
    localparam int          PRE_W           = 7;

    // cycles that the internal reset lingers after its bit clears
    localparam logic [1:0]  RST_RELEASE_CYC = 2'h2;

endpackage : swk_pkg

/* File: src/swk_tick_if.sv */
// run request and advance tick between core and prescaler
`timescale 1ns/1ps
`default_nettype none
interface swk_tick_if;
    logic run;
    logic tick;
    modport pre  (input run,  output tick);
    modport core (output run, input tick);
endinterface : swk_tick_if
`default_nettype wire

/* File: src/swk_prescaler.sv */
// slow tick synchroniser and divide-by-128 prescaler
`timescale 1ns/1ps
`default_nettype none
module swk_prescaler
    import swk_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_b,
    input  wire logic   tick_pin_in,
    swk_tick_if.pre     tif
);
    import swk_pkg::*;

    localparam logic [PRE_W-1:0] PRE_LAST  = PRE_W'(PRESCALE_DIV - 1);
    localparam logic [PRE_W-1:0] PRE_START = PRE_W'(PRESCALE_DIV - FIRST_TICK_EDGES);

    typedef struct packed {
        logic             sync1;
        logic             sync2;
        logic             last;
        logic [PRE_W-1:0] pre;
        logic             tick;
    } swk_pre_s;

    swk_pre_s st_ff;
    swk_pre_s nxt_st;

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sync1 = tick_pin_in;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.last  = st_ff.sync2;
        nxt_st.tick  = 1'b0;
        if (!tif.run) begin
            // first advance after 64 edges, later ones every 128
            nxt_st.pre = PRE_START;
        end else if (st_ff.sync2 && !st_ff.last) begin
            if (st_ff.pre == PRE_LAST) begin
                nxt_st.pre  = '0;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.pre = st_ff.pre + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '{sync1: 1'b0, sync2: 1'b0, last: 1'b0, pre: PRE_START, tick: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tif.tick = st_ff.tick;

endmodule : swk_prescaler
`default_nettype wire

/* File: src/swk_counter.sv */
// standby wake counter: 40-bit loadable counter, match logic, byte-wide config space
//
// What this block does
// - 40-bit up-counter that can be preloaded before counting starts.
// - slow tick divided by 128; counter advances once per prescaler period.
// - optionally clear counter to zero when count equals match value.
// - no clear on match while the match value is all zeros.
// - per-bit match indicators, one when counter bit equals match bit.
// - fabric match flag high while count equals match value, with wake-on-match and oscillator enable bits set.
// - power wake match equals fabric match flag exactly.
// - software preloads counter and reads count at the counter addresses.
// - lowest count byte read live and snapshotted; upper count bytes come from the holding register for byte consistency.
// - configuration space is byte-wide, one byte per address.
// - two-bit oscillator mode output driven by the mode field.
// - oscillator select output driven by the oscillator enable bit.
// - in standby counter keeps running and a match can wake the regulator.
// - in sleep, with crystal off, a counter match never wakes the regulator.
// - first increment after 64 tick edges; counter loads only while disabled.
// - both match outputs held low while wake-on-match bit is clear.
// - clear on match is synchronous, on the edge where count equals match.
// - clearing the active-low counter clear bit zeroes all 40 bits.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module swk_counter
    import swk_pkg::*;
(
    input  wire logic                 CLOCK,
    input  wire logic                 RST_B,
    input  wire logic                 SLOW_TICK_CLOCK,
    input  wire logic [ADDR_W-1:0]    ADDR,
    input  wire logic [BYTE_W-1:0]    WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output logic      [BYTE_W-1:0]    RDATA,
    output logic      [1:0]           OSC_MODE_OUT,
    output logic                      OSC_SELECT_OUT,
    output logic                      FABRIC_MATCH_FLAG,
    output logic                      POWER_WAKE_MATCH
);
    import swk_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  hold;
        logic [CNT_W-1:0]  match;
        logic [BYTE_W-1:0] ctrl;
        logic [1:0]        rst_dly;
        logic [BYTE_W-1:0] rdata;
    } swk_core_s;

    swk_core_s st_ff;
    swk_core_s nxt_st;

    swk_tick_if tif ();

    // true when addr falls in the five-byte group starting at base
    function automatic logic in_group(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] off;
        off = addr - base;
        return (addr >= base) && (off < ADDR_W'(NUM_BYTES));
    endfunction : in_group

    function automatic logic [BYTE_W-1:0] pick_byte(input logic [CNT_W-1:0] val,
                                                   input logic [IDX_W-1:0]  idx);
        return val[int'(idx)*BYTE_W +: BYTE_W];
    endfunction : pick_byte

    logic [IDX_W-1:0] byte_idx;
    logic             hold_rst;
    logic             cnt_en;
    logic             run;
    logic             cnt_eq;
    logic [CNT_W-1:0] bit_match;
    logic             wake_ok;
    logic             clr_match;

    assign byte_idx  = ADDR[IDX_W-1:0];
    // internal reset lingers two cycles after the control bit is cleared
    assign hold_rst  = st_ff.ctrl[CTL_RTC_RST] || (st_ff.rst_dly != 2'h0);
    assign cnt_en    = st_ff.ctrl[CTL_CNT_EN];
    assign run       = cnt_en && !hold_rst;
    assign bit_match = ~(st_ff.cnt ^ st_ff.match);
    assign cnt_eq    = (st_ff.cnt == st_ff.match);
    // crystal off means sleep; a match must not wake the regulator then
    assign wake_ok   = st_ff.ctrl[CTL_WAKE_MATCH] && st_ff.ctrl[CTL_OSC_EN];
    assign clr_match = run && st_ff.ctrl[CTL_CLR_MATCH] && cnt_eq
                       && (st_ff.match != CNT_ZERO);

    assign tif.run = run;

    swk_prescaler u_pre (
        .clk         (CLOCK),
        .rst_b       (RST_B),
        .tick_pin_in (SLOW_TICK_CLOCK),
        .tif         (tif.pre)
    );

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.rdata = BYTE_ZERO;

        if (st_ff.ctrl[CTL_RTC_RST]) begin
            nxt_st.rst_dly = RST_RELEASE_CYC;
        end else if (st_ff.rst_dly != 2'h0) begin
            nxt_st.rst_dly = st_ff.rst_dly - 1'b1;
        end

        // counter next value, highest priority first
        if (hold_rst || !st_ff.ctrl[CTL_CLR_N]) begin
            nxt_st.cnt = CNT_ZERO;
        end else if (clr_match) begin
            nxt_st.cnt = CNT_ZERO;
        end else if (run && tif.tick) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (WR && !cnt_en && in_group(ADDR, ADR_COUNTER)) begin
            nxt_st.cnt[int'(byte_idx)*BYTE_W +: BYTE_W] = WDATA;
        end

        if (WR && in_group(ADDR, ADR_MATCH)) begin
            nxt_st.match[int'(byte_idx)*BYTE_W +: BYTE_W] = WDATA;
        end
        if (WR && (ADDR == ADR_CTRL)) begin
            nxt_st.ctrl = WDATA;
        end

        if (RD) begin
            if (in_group(ADDR, ADR_COUNTER)) begin
                if (byte_idx == '0) begin
                    // lowest byte opens a count access and freezes the snapshot
                    nxt_st.hold  = st_ff.cnt;
                    nxt_st.rdata = pick_byte(st_ff.cnt, byte_idx);
                end else begin
                    nxt_st.rdata = pick_byte(st_ff.hold, byte_idx);
                end
            end else if (in_group(ADDR, ADR_MATCH)) begin
                nxt_st.rdata = pick_byte(st_ff.match, byte_idx);
            end else if (in_group(ADDR, ADR_MATCHBIT)) begin
                nxt_st.rdata = pick_byte(bit_match, byte_idx);
            end else if (ADDR == ADR_CTRL) begin
                nxt_st.rdata = st_ff.ctrl;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            st_ff <= '{cnt: CNT_ZERO, hold: CNT_ZERO, match: CNT_ZERO, ctrl: CTRL_RESET,
                       rst_dly: 2'h0, rdata: BYTE_ZERO};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign RDATA             = st_ff.rdata;
    assign OSC_MODE_OUT      = st_ff.ctrl[CTL_MODE_HI:CTL_MODE_LO];
    assign OSC_SELECT_OUT    = st_ff.ctrl[CTL_OSC_EN];
    assign FABRIC_MATCH_FLAG = wake_ok && cnt_eq;
    assign POWER_WAKE_MATCH  = FABRIC_MATCH_FLAG;

endmodule : swk_counter
`default_nettype wire

/* File: testbench/swk_counter_assertions.sv */
// port checker for the standby wake counter
`timescale 1ns/1ps
`default_nettype none
module swk_counter_chk
    import swk_pkg::*;
(
    input wire logic              CLOCK,
    input wire logic              RST_B,
    input wire logic              SLOW_TICK_CLOCK,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [BYTE_W-1:0] WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [BYTE_W-1:0] RDATA,
    input wire logic [1:0]        OSC_MODE_OUT,
    input wire logic              OSC_SELECT_OUT,
    input wire logic              FABRIC_MATCH_FLAG,
    input wire logic              POWER_WAKE_MATCH
);
    import swk_pkg::*;
    logic [7:0] ctl_ff;
    logic [7:0] mt_ff [NUM_BYTES];
    logic       mnz;
    assign mnz = |{mt_ff[0], mt_ff[1], mt_ff[2], mt_ff[3], mt_ff[4]};
    // shadow of control and match bytes
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ctl_ff <= CTRL_RESET;
            mt_ff  <= '{default: BYTE_ZERO};
        end else if (WR && ADDR == ADR_CTRL) begin
            ctl_ff <= WDATA;
        end else if (WR && ADDR >= ADR_MATCH && ADDR <= 8'h4c) begin
            mt_ff[ADDR[2:0]] <= WDATA;
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    property p_pair; POWER_WAKE_MATCH == FABRIC_MATCH_FLAG; endproperty
    a_pair: assert property (p_pair) else $error("wake output differs");
    property p_mode; WR && ADDR == ADR_CTRL |=> OSC_MODE_OUT == $past(WDATA[4:3]); endproperty
    a_mode: assert property (p_mode) else $error("mode output wrong");
    property p_sel; OSC_SELECT_OUT == ctl_ff[CTL_OSC_EN]; endproperty
    a_sel: assert property (p_sel) else $error("select output wrong");
    property p_gate; FABRIC_MATCH_FLAG |-> ctl_ff[CTL_WAKE_MATCH]; endproperty
    a_gate: assert property (p_gate) else $error("flag while wake off");
    property p_sleep; !ctl_ff[CTL_OSC_EN] |-> !FABRIC_MATCH_FLAG; endproperty
    a_sleep: assert property (p_sleep) else $error("flag while crystal off");
    property p_idle; !RD |=> RDATA == BYTE_ZERO; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_unmap; RD && ADDR == 8'h00 |=> RDATA == BYTE_ZERO; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_mbit; RD && ADDR == ADR_MATCHBIT && FABRIC_MATCH_FLAG |=> RDATA == 8'hff; endproperty
    a_mbit: assert property (p_mbit) else $error("match bits not all set");
    property p_clr;
        FABRIC_MATCH_FLAG && mnz && ctl_ff[CTL_CLR_MATCH] && ctl_ff[CTL_CNT_EN] && !ctl_ff[CTL_RTC_RST] && !WR
            |=> !FABRIC_MATCH_FLAG;
    endproperty
    a_clr: assert property (p_clr) else $error("no clear on match");
    cover property (FABRIC_MATCH_FLAG && mnz);
    cover property (RD && ADDR == ADR_MATCHBIT && FABRIC_MATCH_FLAG);
    cover property (OSC_MODE_OUT == 2'h3);
endmodule : swk_counter_chk
bind swk_counter swk_counter_chk u_chk (.CLOCK(CLOCK), .RST_B(RST_B), .SLOW_TICK_CLOCK(SLOW_TICK_CLOCK),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OSC_MODE_OUT(OSC_MODE_OUT),
    .OSC_SELECT_OUT(OSC_SELECT_OUT), .FABRIC_MATCH_FLAG(FABRIC_MATCH_FLAG), .POWER_WAKE_MATCH(POWER_WAKE_MATCH));
`default_nettype wire

/* File: testbench/swk_partner.sv */
// crystal oscillator and power sequencer stand-in
`timescale 1ns/1ps
`default_nettype none
module swk_partner #(parameter int HALF_NS = 800) (
    input  wire logic osc_enable,
    input  wire logic wake_match,
    input  wire logic regulator_keep_on,
    output logic      osc_clock_out,
    output logic      regulator_on
);
    logic woke;
    initial osc_clock_out = 1'b0;
    initial woke = 1'b0;
    // clock stands low while the crystal is off
    always #(HALF_NS) osc_clock_out = osc_enable ? ~osc_clock_out : 1'b0;
    always @(posedge wake_match) woke = 1'b1;
    assign regulator_on = regulator_keep_on | woke;
endmodule : swk_partner
`default_nettype wire

/* File: testbench/swk_counter_tb.sv */
// self-checking bench for the standby wake counter
`timescale 1ns/1ps
`default_nettype none
module swk_counter_tb;
    import swk_pkg::*;
    logic       CLOCK, RST_B, WR, RD, keep_on, reg_on, slow, sel, flag, wake;
    logic [7:0] ADDR, WDATA, RDATA;
    logic [1:0] mode;
    int         n_mismatch, total_checks;
    swk_counter dut (.CLOCK(CLOCK), .RST_B(RST_B), .SLOW_TICK_CLOCK(slow), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .OSC_MODE_OUT(mode), .OSC_SELECT_OUT(sel),
        .FABRIC_MATCH_FLAG(flag), .POWER_WAKE_MATCH(wake));
    swk_partner xtal (.osc_enable(sel), .wake_match(wake), .regulator_keep_on(keep_on),
        .osc_clock_out(slow), .regulator_on(reg_on));
    always #50 CLOCK = ~CLOCK;
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
        total_checks++;
        if (v !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", s, e, v);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        @(posedge CLOCK);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        @(negedge CLOCK);
        chk($sformatf("addr %h", a), e, RDATA);
        @(posedge CLOCK);
    endtask : rd
    task automatic wr40(input logic [7:0] b, input logic [39:0] v);
        for (int i = 0; i < NUM_BYTES; i++) wr(b + 8'(i), v[8*i +: 8]);
    endtask : wr40
    task automatic rd40(input logic [7:0] b, input logic [39:0] v);
        for (int i = 0; i < NUM_BYTES; i++) rd(b + 8'(i), v[8*i +: 8]);
    endtask : rd40
    task automatic tick(input int n, input logic [7:0] e);
        repeat (n) @(posedge slow);
        repeat (8) @(posedge CLOCK);
        rd(ADR_COUNTER, e);
    endtask : tick
    task automatic stop_test();
        if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial begin
        repeat (30000) @(posedge CLOCK);
        n_mismatch++;
        stop_test();
    end
    initial begin
        {CLOCK, RST_B, WR, RD, ADDR, WDATA} = '0;
        keep_on = 1'b1;
        repeat (20) @(posedge CLOCK);
        RST_B <= 1'b1;
        @(posedge CLOCK);
        rd(ADR_CTRL, 8'h00);
        rd(8'h00, 8'h00);
        wr(ADR_CTRL, 8'h02);
        wr40(ADR_COUNTER, 40'h12_3456_789a);
        rd40(ADR_COUNTER, 40'h12_3456_789a);
        wr(ADR_CTRL, 8'h00);
        rd40(ADR_COUNTER, 40'h0);
        for (int m = 0; m < 4; m++) begin
            wr(ADR_CTRL, {3'h0, m[1:0], 3'h3});
            chk("mode", {6'h00, m[1:0]}, {6'h00, mode});
            chk("select", 8'h01, {7'h00, sel});
        end
        @(negedge slow);
        @(posedge CLOCK);
        wr(ADR_CTRL, 8'h5b);
        tick(63, 8'h00);
        tick(1, 8'h01);
        tick(127, 8'h01);
        tick(1, 8'h02);
        wr(ADR_COUNTER, 8'h55);
        rd(ADR_COUNTER, 8'h02);
        wr40(ADR_MATCH, 40'h3);
        wr(ADR_CTRL, 8'h67);
        keep_on <= 1'b0;
        for (int i = 0; i < 3000 && flag !== 1'b1; i++) @(negedge CLOCK);
        chk("flag", 8'h01, {7'h00, flag});
        chk("wake", 8'h01, {7'h00, wake});
        chk("regulator", 8'h01, {7'h00, reg_on});
        @(negedge CLOCK);
        chk("cleared flag", 8'h00, {7'h00, flag});
        @(posedge CLOCK);
        rd(ADR_COUNTER, 8'h00);
        wr(ADR_CTRL, 8'h01);
        wr40(ADR_MATCH, 40'h0);
        wr(ADR_CTRL, 8'h67);
        rd(ADR_MATCHBIT, 8'hff);
        wr(ADR_CTRL, 8'h47);
        chk("gated flag", 8'h00, {7'h00, flag});
        wr(ADR_CTRL, 8'h66);
        chk("sleep flag", 8'h00, {7'h00, flag});
        wr(ADR_CTRL, 8'h67);
        tick(64, 8'h01);
        rd(ADR_MATCHBIT, 8'hfe);
        wr(ADR_CTRL, 8'h03);
        wr(ADR_COUNTER, 8'hff);
        @(negedge slow);
        @(posedge CLOCK);
        wr(ADR_CTRL, 8'h43);
        tick(63, 8'hff);
        @(posedge slow);
        repeat (8) @(posedge CLOCK);
        rd(ADR_COUNTER + 8'h01, 8'h00);
        rd40(ADR_COUNTER, 40'h100);
        wr(ADR_CTRL, 8'hc3);
        rd40(ADR_COUNTER, 40'h0); // soft reset clears the count
        stop_test();
    end
endmodule : swk_counter_tb
`default_nettype wire
